// *** bmwm_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module bmwm_exec (
	// Clock and reset
	input  wire  logic        core_clk,
	input  wire  logic        sys_rst,
	// Instruction request
	input  wire  logic        start,
	input  wire  logic [7:0]  opcode,
	input  wire  logic [7:0]  op1Byte,
	input  wire  logic [7:0]  op2Byte,
	input  wire  logic [7:0]  op3Byte,
	// Operand values from the register file and program memory
	input  wire  logic [15:0] pairIn,
	input  wire  logic [7:0]  srcByteIn,
	input  wire  logic [15:0] srcWordIn,
	input  wire  logic [7:0]  mulDstIn,
	input  wire  logic [7:0]  mulSrcIn,
	input  wire  logic [15:0] ipIn,
	input  wire  logic [15:0] progWordIn,
	// Status
	output logic              busy,
	output logic              done,
	output logic              illegal,
	output logic [2:0]        instrLen,
	// Register file write
	output logic              regWrEn,
	output logic              regWrWork,
	output logic [7:0]        regWrAddr,
	output logic [15:0]       regWrData,
	// Memory write
	output logic              memWrEn,
	output logic              memIsData,
	output logic [15:0]       memAddr,
	output logic [7:0]        memData,
	// Program counter and instruction pointer
	output logic              pcLoad,
	output logic [15:0]       pcValue,
	output logic              ipLoad,
	output logic [15:0]       ipValue,
	// Flags
	output logic              flagWrEn,
	output logic [3:0]        flagsOut
);
	bmwm_pkg::bmwm_state_type state_reg;
	bmwm_pkg::bmwm_state_type state_next;

	function automatic logic [4:0] cycles_of(input logic [7:0] opc);
		if (opc == bmwm_pkg::OPC_STORE_DEC || opc == bmwm_pkg::OPC_STORE_INC) begin
			cycles_of = bmwm_pkg::CYC_STORE;
		end else if (opc == bmwm_pkg::OPC_WORD_PAIR || opc == bmwm_pkg::OPC_WORD_PTR ||
			opc == bmwm_pkg::OPC_WORD_LIT) begin
			cycles_of = bmwm_pkg::CYC_WORD;
		end else if (opc == bmwm_pkg::OPC_MUL_REG || opc == bmwm_pkg::OPC_MUL_PTR ||
			opc == bmwm_pkg::OPC_MUL_LIT) begin
			cycles_of = bmwm_pkg::CYC_MUL;
		end else if (opc == bmwm_pkg::OPC_DISPATCH) begin
			cycles_of = bmwm_pkg::CYC_DISPATCH;
		end else if (opc == bmwm_pkg::OPC_IDLE) begin
			cycles_of = bmwm_pkg::CYC_IDLE;
		end else begin
			cycles_of = bmwm_pkg::CYC_ILLEGAL;
		end
	endfunction : cycles_of

	// Decode of the presented opcode.
	wire        isStoreDec = (opcode == bmwm_pkg::OPC_STORE_DEC);
	wire        isStoreInc = (opcode == bmwm_pkg::OPC_STORE_INC);
	wire        isStore    = isStoreDec | isStoreInc;
	wire        isWordLit  = (opcode == bmwm_pkg::OPC_WORD_LIT);
	wire        isWord     = (opcode == bmwm_pkg::OPC_WORD_PAIR) |
		(opcode == bmwm_pkg::OPC_WORD_PTR) | isWordLit;
	wire        isMulLit   = (opcode == bmwm_pkg::OPC_MUL_LIT);
	wire        isMul      = (opcode == bmwm_pkg::OPC_MUL_REG) |
		(opcode == bmwm_pkg::OPC_MUL_PTR) | isMulLit;
	wire        isDispatch = (opcode == bmwm_pkg::OPC_DISPATCH);
	wire        isIdle     = (opcode == bmwm_pkg::OPC_IDLE);
	wire        isKnown    = isStore | isWord | isMul | isDispatch | isIdle;
	wire        accept     = start && (state_reg == bmwm_pkg::ST_IDLE);
	wire        expired;
	wire        last       = (state_reg == bmwm_pkg::ST_RUN) && expired;
	wire [4:0]  loadCount  = cycles_of(opcode) - bmwm_pkg::CYC_LOAD_ADJ;

	// Operand arithmetic.
	wire [15:0] steppedPair = isStoreDec ? pairIn - bmwm_pkg::PAIR_STEP :
		pairIn + bmwm_pkg::PAIR_STEP; // RULE10 RULE1 RULE4
	wire [7:0]  mulSrc      = isMulLit ? op1Byte : mulSrcIn;
	wire [15:0] product     = mulDstIn * mulSrc; // RULE6
	wire [15:0] wordValue   = isWordLit ? {op2Byte, op3Byte} : srcWordIn; // RULE5
	wire [7:0]  wordDst     = isWordLit ? op1Byte : op2Byte;
	wire [3:0]  productFlags;
	wire [2:0]  lenNext     = isStore ? bmwm_pkg::LEN_STORE :
		isWordLit ? bmwm_pkg::LEN_WORD_LIT :
		isWord ? bmwm_pkg::LEN_WORD :
		isMul ? bmwm_pkg::LEN_MUL : bmwm_pkg::LEN_ONE; // RULE2 RULE9

	assign productFlags[bmwm_pkg::FLAG_C] = (product > bmwm_pkg::BYTE_LIMIT); // RULE7
	assign productFlags[bmwm_pkg::FLAG_Z] = (product == 16'h0000); // RULE7
	assign productFlags[bmwm_pkg::FLAG_S] = product[15]; // RULE7
	assign productFlags[bmwm_pkg::FLAG_V] = 1'b0; // RULE7

	bmwm_cycle_timer u_timer (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.load      (accept),
		.loadCount (loadCount),
		.expired   (expired)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			bmwm_pkg::ST_IDLE: begin
				if (accept) begin
					state_next = bmwm_pkg::ST_RUN;
				end
			end
			bmwm_pkg::ST_RUN: begin
				if (last) begin
					state_next = bmwm_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = bmwm_pkg::ST_IDLE;
			end
		endcase
	end

	// Pending effects are captured at acceptance and released in the final cycle.
	logic wantReg_reg;
	logic wantMem_reg;
	logic wantPc_reg;
	logic wantFlag_reg;
	logic wantIllegal_reg;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg       <= bmwm_pkg::ST_IDLE;
			wantReg_reg     <= 1'b0;
			wantMem_reg     <= 1'b0;
			wantPc_reg      <= 1'b0;
			wantFlag_reg    <= 1'b0;
			wantIllegal_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (accept) begin
				wantReg_reg     <= isStore | isWord | isMul;
				wantMem_reg     <= isStore; // RULE1 RULE4
				wantPc_reg      <= isDispatch; // RULE8
				wantFlag_reg    <= isMul; // RULE1 RULE4 RULE5 RULE8 RULE9
				wantIllegal_reg <= !isKnown;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			instrLen  <= bmwm_pkg::LEN_ONE;
			regWrWork <= 1'b0;
			regWrAddr <= 8'h00;
			regWrData <= 16'h0000;
			memIsData <= 1'b0;
			memAddr   <= 16'h0000;
			memData   <= 8'h00;
			pcValue   <= 16'h0000;
			ipValue   <= 16'h0000;
			flagsOut  <= 4'h0;
		end else if (accept) begin
			instrLen  <= lenNext;
			regWrWork <= isStore;
			regWrAddr <= isStore ? {4'h0, op1Byte[3:0] & bmwm_pkg::PAIR_EVEN} :
				isWord ? wordDst : op2Byte;
			regWrData <= isStore ? steppedPair : isWord ? wordValue : product;
			memIsData <= op1Byte[0]; // RULE3
			memAddr   <= steppedPair; // RULE1 RULE4
			memData   <= srcByteIn;
			pcValue   <= progWordIn; // RULE8
			ipValue   <= ipIn + bmwm_pkg::IP_STEP; // RULE8
			flagsOut  <= productFlags;
		end
	end

	assign busy     = (state_reg == bmwm_pkg::ST_RUN);
	assign done     = last;
	assign illegal  = last && wantIllegal_reg;
	assign regWrEn  = last && wantReg_reg;
	assign memWrEn  = last && wantMem_reg;
	assign pcLoad   = last && wantPc_reg;
	assign ipLoad   = last && wantPc_reg;
	assign flagWrEn = last && wantFlag_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_store_dec;
		accept && isStoreDec;
	endsequence
	sequence s_store_inc;
		accept && isStoreInc;
	endsequence
	sequence s_mul_start;
		accept && isMul;
	endsequence

	a_store_dec_timing: assert property (s_store_dec |-> !done [*8] ##6 memWrEn && done
		&& memAddr == $past(pairIn, 13) - 16'h0001) // RULE2
		else $error("pre-decrement store did not write after fourteen cycles");
	a_store_inc_addr: assert property (s_store_inc |-> ##13 memWrEn
		&& memAddr == $past(pairIn, 13) + 16'h0001) // RULE4
		else $error("pre-increment store address or timing wrong");
	a_mem_select: assert property ((accept && isStore) |->
		##13 memIsData == $past(op1Byte[0], 13)) // RULE3
		else $error("memory space select does not follow pair parity");
	a_store_no_flags: assert property (memWrEn |-> !flagWrEn && !pcLoad) // RULE1
		else $error("store touched flags or program counter");
	a_word_timing: assert property ((accept && isWord) |-> ##7 regWrEn && !flagWrEn) // RULE5
		else $error("word move not complete in eight cycles");
	a_mul_timing: assert property (s_mul_start |-> ##21 flagWrEn && regWrEn && instrLen == 3'h3) // RULE6
		else $error("multiply not complete in 22 cycles");
	a_mul_flags: assert property (flagWrEn |-> flagsOut[3] == (regWrData > 16'h00FF)
		&& flagsOut[2] == (regWrData == 16'h0000) && flagsOut[1] == regWrData[15]
		&& !flagsOut[0]) // RULE7
		else $error("multiply flags disagree with product");
	a_dispatch_load: assert property ((accept && isDispatch) |-> ##9 pcLoad && ipLoad
		&& ipValue == $past(ipIn, 9) + 16'h0002 && pcValue == $past(progWordIn, 9)) // RULE8
		else $error("dispatch did not load counter and pointer in ten cycles");
	a_idle_quiet: assert property ((accept && isIdle) |-> (!regWrEn && !memWrEn && !flagWrEn
		&& !pcLoad) [*4] ##0 done) // RULE9
		else $error("idle instruction changed state or took wrong time");
endmodule : bmwm_exec
`default_nettype wire

// *** bmwm_pkg.sv ***
// Behaviour
// RULE1: Pre-decrement stores lower the pair first, then write the source byte; no flags.
// RULE2: Pre-decrement store is opcode F2, two bytes, fourteen cycles.
// RULE3: Even pair number selects program memory, odd selects external data memory.
// RULE4: Pre-increment store is opcode F3: raise pair, write byte, fourteen cycles, no flags.
// RULE5: Word move copies sixteen bits; C4, C5 three bytes, C6 four; eight cycles.
// RULE6: Multiply source by even register of pair; 84, 85, 86; three bytes; 22 cycles.
// RULE7: Multiply sets carry above 255, zero, sign from bit 15, clears overflow.
// RULE8: Dispatch 0F loads counter from word at pointer, pointer plus two, ten cycles.
// RULE9: Idle FF changes nothing, one byte, four cycles.
// RULE10: Pair step works on the whole sixteen-bit value with carry or borrow.
package bmwm_pkg;
	localparam logic [7:0]  OPC_STORE_DEC = 8'hF2;
	localparam logic [7:0]  OPC_STORE_INC = 8'hF3;
	localparam logic [7:0]  OPC_WORD_PAIR = 8'hC4;
	localparam logic [7:0]  OPC_WORD_PTR  = 8'hC5;
	localparam logic [7:0]  OPC_WORD_LIT  = 8'hC6;
	localparam logic [7:0]  OPC_MUL_REG   = 8'h84;
	localparam logic [7:0]  OPC_MUL_PTR   = 8'h85;
	localparam logic [7:0]  OPC_MUL_LIT   = 8'h86;
	localparam logic [7:0]  OPC_DISPATCH  = 8'h0F;
	localparam logic [7:0]  OPC_IDLE      = 8'hFF;

	localparam logic [4:0]  CYC_STORE     = 5'h0E;
	localparam logic [4:0]  CYC_WORD      = 5'h08;
	localparam logic [4:0]  CYC_MUL       = 5'h16;
	localparam logic [4:0]  CYC_DISPATCH  = 5'h0A;
	localparam logic [4:0]  CYC_IDLE      = 5'h04;
	localparam logic [4:0]  CYC_ILLEGAL   = 5'h02;
	localparam logic [4:0]  CYC_LOAD_ADJ  = 5'h02;
	localparam logic [4:0]  TIMER_RESET   = 5'h00;

	localparam logic [2:0]  LEN_STORE     = 3'h2;
	localparam logic [2:0]  LEN_WORD      = 3'h3;
	localparam logic [2:0]  LEN_WORD_LIT  = 3'h4;
	localparam logic [2:0]  LEN_MUL       = 3'h3;
	localparam logic [2:0]  LEN_ONE       = 3'h1;

	localparam logic [15:0] BYTE_LIMIT    = 16'h00FF;
	localparam logic [15:0] PAIR_STEP     = 16'h0001;
	localparam logic [15:0] IP_STEP       = 16'h0002;
	localparam logic [3:0]  PAIR_EVEN     = 4'hE;

	localparam int          FLAG_C        = 3;
	localparam int          FLAG_Z        = 2;
	localparam int          FLAG_S        = 1;
	localparam int          FLAG_V        = 0;

	typedef enum logic {ST_IDLE, ST_RUN} bmwm_state_type;
endpackage : bmwm_pkg

// *** bmwm_cycle_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module bmwm_cycle_timer (
	// Clock and reset
	input  wire  logic       core_clk,
	input  wire  logic       sys_rst,
	// Control
	input  wire  logic       load,
	input  wire  logic [4:0] loadCount,
	// Status
	output logic             expired
);
	logic [4:0] count_reg;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count_reg <= bmwm_pkg::TIMER_RESET;
		end else if (load) begin
			count_reg <= loadCount;
		end else if (count_reg != bmwm_pkg::TIMER_RESET) begin
			count_reg <= count_reg - 5'h01;
		end
	end

	assign expired = (count_reg == bmwm_pkg::TIMER_RESET);
endmodule : bmwm_cycle_timer
`default_nettype wire

// *** bmwm_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Program and external data memory on the far side of the store and dispatch paths.
module bmwm_mem_model (
	// Clock
	input  wire logic        core_clk,
	// Write side
	input  wire logic        memWrEn,
	input  wire logic        memIsData,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memData,
	// Dispatch read
	input  wire logic [15:0] ipIn,
	output var  logic [15:0] progWordIn
);
	logic [7:0] progMem [logic [15:0]];
	logic [7:0] dataMem [logic [15:0]];
	// Unwritten bytes read as a pattern tied to the address, never as a stale value.
	function automatic logic [7:0] rdb(input logic [15:0] a);
		return progMem.exists(a) ? progMem[a] : (a[7:0] ^ 8'h5A);
	endfunction : rdb
	always @(posedge core_clk) begin
		if (memWrEn && memIsData) dataMem[memAddr] = memData;
		if (memWrEn && !memIsData) progMem[memAddr] = memData;
	end
	always @* progWordIn = {rdb(ipIn), rdb(ipIn + 16'h0001)};
endmodule : bmwm_mem_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nErrors++; \
	$display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb;
	logic        core_clk, sys_rst, start, busy, done, illegal, regWrEn, regWrWork;
	logic        memWrEn, memIsData, pcLoad, ipLoad, flagWrEn;
	logic [7:0]  opcode, op1Byte, op2Byte, op3Byte, srcByteIn, mulDstIn, mulSrcIn;
	logic [7:0]  regWrAddr, memData;
	logic [15:0] pairIn, srcWordIn, ipIn, progWordIn, regWrData, memAddr, pcValue, ipValue;
	logic [2:0]  instrLen;
	logic [3:0]  flagsOut;
	logic [31:0] seed = 32'h9EDB;
	int          nErrors = 0;
	int          nTests = 0;
	logic [7:0]  ops [11] = '{8'hF2, 8'hF3, 8'hC4, 8'hC5, 8'hC6, 8'h84, 8'h85, 8'h86,
		8'h0F, 8'hFF, 8'h00};
	// Expected register-file writes, queued at request and taken at completion.
	logic [24:0] expQ [$];
	wire  [24:0] regWr  = {regWrWork, regWrAddr, regWrData};
	wire  [24:0] memWr  = {memData, memIsData, memAddr};
	wire  [6:0]  pulses = {busy, illegal, regWrEn, memWrEn, pcLoad, ipLoad, flagWrEn};
	bmwm_exec i_dut (.core_clk, .sys_rst, .start, .opcode, .op1Byte, .op2Byte, .op3Byte,
		.pairIn, .srcByteIn, .srcWordIn, .mulDstIn, .mulSrcIn, .ipIn, .progWordIn, .busy,
		.done, .illegal, .instrLen, .regWrEn, .regWrWork, .regWrAddr, .regWrData, .memWrEn,
		.memIsData, .memAddr, .memData, .pcLoad, .pcValue, .ipLoad, .ipValue, .flagWrEn,
		.flagsOut);
	bmwm_mem_model i_mem (.core_clk, .memWrEn, .memIsData, .memAddr, .memData, .ipIn,
		.progWordIn);
	always #20 core_clk = ~core_clk;
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd
	task automatic wrap_up();
		if (nErrors == 0 && nTests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	task automatic run(input logic [7:0] op, input logic [15:0] pr, input logic [7:0] md, ms);
		int n, len, k;
		logic [5:0] pl;
		logic [15:0] w, p;
		logic [24:0] er;
		logic [31:0] d;
		opcode = op; op1Byte = 8'(rnd()); op2Byte = 8'(rnd()); op3Byte = 8'(rnd());
		pairIn = pr; mulDstIn = md; mulSrcIn = ms; srcByteIn = 8'(rnd());
		srcWordIn = rnd(); ipIn = rnd(); start = 1'b1;
		p = md * ((op == 8'h86) ? op1Byte : ms);
		w = (op == 8'hF2) ? pr - 16'h0001 : pr + 16'h0001;
		if (op == 8'hF2 || op == 8'hF3) expQ.push_back({5'h10, op1Byte[3:0] & 4'hE, w});
		else if (op == 8'hC6) expQ.push_back({1'b0, op1Byte, op2Byte, op3Byte});
		else if (op == 8'hC4 || op == 8'hC5) expQ.push_back({1'b0, op2Byte, srcWordIn});
		else expQ.push_back({1'b0, op2Byte, p});
		case (op)
			8'hF2, 8'hF3: begin n = 14; len = 2; pl = 6'b011000; end
			8'hC4, 8'hC5: begin n = 8; len = 3; pl = 6'b010000; end
			8'hC6: begin n = 8; len = 4; pl = 6'b010000; end
			8'h84, 8'h85, 8'h86: begin n = 22; len = 3; pl = 6'b010001; end
			8'h0F: begin n = 10; len = 1; pl = 6'b000110; end
			8'hFF: begin n = 4; len = 1; pl = 6'b000000; end
			default: begin n = 2; len = 1; pl = 6'b100000; end
		endcase
		@(posedge core_clk); #1;
		// Start stays up with a bad opcode while busy, which must be ignored, and the
		// pair, word, pointer and multiply operands move on, since they may be sampled only at acceptance.
		d = {progWordIn, ipIn + 16'h0002};
		opcode = 8'h00; pairIn = rnd(); srcWordIn = rnd(); ipIn = rnd();
		mulDstIn = 8'(rnd()); mulSrcIn = 8'(rnd());
		// The count includes the request cycle itself.
		k = 2;
		while (done !== 1'b1 && k < 40) begin @(posedge core_clk); #1; k++; end
		start = 1'b0;
		er = expQ.pop_front();
		`CHK("cycles", n, k)
		`CHK("pulses", {1'b1, pl}, pulses)
		`CHK("instrLen", 3'(len), instrLen)
		case (op)
			8'hF2, 8'hF3: begin
				`CHK("store", {srcByteIn, op1Byte[0], w}, memWr)
				`CHK("pair", er, regWr)
			end
			8'hC4, 8'hC5: `CHK("word", er, regWr)
			8'hC6: `CHK("word", er, regWr)
			8'h84, 8'h85, 8'h86: begin
				`CHK("product", er, regWr)
				`CHK("flags", {p > 16'h00FF, p == 16'h0000, p[15], 1'b0}, flagsOut)
			end
			8'h0F: `CHK("dispatch", d, {pcValue, ipValue})
			default: ;
		endcase
		@(posedge core_clk); #1;
		`CHK("idle", 2'b00, {busy, done})
		if (op == 8'hF2 || op == 8'hF3)
			`CHK("mem", srcByteIn, op1Byte[0] ? i_mem.dataMem[w] : i_mem.progMem[w])
	endtask : run
	initial begin
		core_clk = 1'b0; sys_rst = 1'b1; start = 1'b0; opcode = 8'h00; op1Byte = 8'h00;
		op2Byte = 8'h00; op3Byte = 8'h00; srcByteIn = 8'h00; mulDstIn = 8'h00;
		mulSrcIn = 8'h00; pairIn = 16'h0000; srcWordIn = 16'h0000; ipIn = 16'h0000;
		repeat (2) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		run(8'hF2, 16'h3000, 8'h00, 8'h00);
		run(8'hF2, 16'h0000, 8'h00, 8'h00);
		run(8'hF3, 16'h21FF, 8'h00, 8'h00);
		run(8'hF3, 16'hFFFF, 8'h00, 8'h00);
		run(8'h84, 16'h0000, 8'h00, 8'h37);
		run(8'h85, 16'h0000, 8'hFF, 8'hFF);
		run(8'h84, 16'h0000, 8'h20, 8'h09);
		for (int i = 0; i < 44; i++) run(ops[i % 11], rnd(), 8'(rnd()), 8'(rnd()));
		wrap_up();
	end
	initial begin
		#160000;
		nErrors++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
